// ==== design/mcc_pkg.sv ====
// constants and types shared by the surface-to-controller encoder
package mcc_pkg;
	// ------------------------------------------------------------
	// message framing
	// ------------------------------------------------------------
	localparam logic [7:0] CC_STATUS = 8'hB0; // control change, channel one
	localparam logic [6:0] CC_BASE_FADER = 7'h00;
	localparam logic [6:0] CC_BASE_KNOB = 7'h10;
	localparam logic [6:0] CC_BASE_CHSEL = 7'h40;
	localparam logic [6:0] CC_BASE_KSEL = 7'h50;
	localparam logic [6:0] VAL_ON = 7'h7F;
	localparam logic [6:0] VAL_OFF = 7'h00;
	// ------------------------------------------------------------
	// surface shape and groups
	// ------------------------------------------------------------
	localparam int NUM_CH = 16;
	localparam int NUM_CTL = 64;
	localparam logic [1:0] GRP_FADER = 2'h0;
	localparam logic [1:0] GRP_KNOB = 2'h1;
	localparam logic [1:0] GRP_CHSEL = 2'h2;
	localparam logic [1:0] GRP_KSEL = 2'h3;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 1000; // display timer step, microseconds
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam logic [7:0] DISP_MS = 8'hC8; // momentary value display, ms
	// ------------------------------------------------------------
	// sender states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_STAT = 4'h2,
		ST_NUM = 4'h4,
		ST_VAL = 4'h8
	} mcc_state_t;
endpackage

// ==== design/mcc_encoder.sv ====
// control surface to MIDI control change encoder
// Summary of operation
// R01: send on channel one when layer active
// R02: output only, positions held locally
// R03: faders use controller numbers 0-15
// R04: knobs use controller numbers 16-31
// R05: channel selects use numbers 64-79
// R06: knob selects use numbers 80-95
// R07: fader and knob values span 0-127
// R08: knobs send absolute positions
// R09: latched switches send 127 on, 0 off
// R10: tally lamp lit while switch on
// R11: take captures all held values
// R12: one snapshot, new one replaces old
// R13: restore loads snapshot and transmits it
// R14: refresh retransmits held values unchanged
// R15: swap exchanges fader/knob and select numbers
// R16: moved control briefly shows its value
// R17: three bytes: status, number, value
// R18: press toggles, release sends nothing
`timescale 1ns/10ps
`default_nettype none
module mcc_encoder
	import mcc_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic I_CLK_SYS,
	input wire logic I_ARST_N,
	input wire logic I_LAYER_ACTIVE,
	input wire logic I_SWAP,
	input wire logic [NUM_CH*7-1:0] I_FADER_POS,
	input wire logic [NUM_CH*7-1:0] I_KNOB_POS,
	input wire logic [NUM_CH-1:0] I_CHSEL_PRESS,
	input wire logic [NUM_CH-1:0] I_KSEL_PRESS,
	input wire logic I_TAKE,
	input wire logic I_RESTORE,
	input wire logic I_REFRESH,
	input wire logic I_TX_READY,
	output logic O_TX_VALID,
	output logic [7:0] O_TX_BYTE,
	output logic [NUM_CH-1:0] O_CHSEL_TALLY,
	output logic [NUM_CH-1:0] O_KSEL_TALLY,
	output logic [NUM_CH-1:0] O_DISP_SHOW,
	output logic [NUM_CH*7-1:0] O_DISP_VALUE
);
	localparam int TW = $clog2(TICK_CYC + 1);

	// ------------------------------------------------------------
	// held surface state and snapshot
	// ------------------------------------------------------------
	logic [6:0] fader [NUM_CH];
	logic [6:0] knob [NUM_CH];
	logic [6:0] fader_prev [NUM_CH];
	logic [6:0] knob_prev [NUM_CH];
	logic [NUM_CH-1:0] chsel;
	logic [NUM_CH-1:0] ksel;
	logic [NUM_CH-1:0] chsel_press_q;
	logic [NUM_CH-1:0] ksel_press_q;
	logic [6:0] snap_fader [NUM_CH];
	logic [6:0] snap_knob [NUM_CH];
	logic [NUM_CH-1:0] snap_chsel;
	logic [NUM_CH-1:0] snap_ksel;
	logic [NUM_CH-1:0] fader_mv;
	logic [NUM_CH-1:0] knob_mv;
	logic [NUM_CH-1:0] chsel_hit;
	logic [NUM_CH-1:0] ksel_hit;

	// movement and press edge detection
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			fader_mv[i] = I_FADER_POS[i*7 +: 7] != fader_prev[i];
			knob_mv[i] = I_KNOB_POS[i*7 +: 7] != knob_prev[i];
		end
		// R18: only the press edge counts
		chsel_hit = I_CHSEL_PRESS & ~chsel_press_q;
		ksel_hit = I_KSEL_PRESS & ~ksel_press_q;
	end

	// input history for change detection
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < NUM_CH; i++) begin
				fader_prev[i] <= 7'h00;
				knob_prev[i] <= 7'h00;
			end
			chsel_press_q <= '0;
			ksel_press_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				fader_prev[i] <= I_FADER_POS[i*7 +: 7];
				knob_prev[i] <= I_KNOB_POS[i*7 +: 7];
			end
			chsel_press_q <= I_CHSEL_PRESS;
			ksel_press_q <= I_KSEL_PRESS;
		end
	end

	// held values; a move in the restore cycle beats the restore
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < NUM_CH; i++) begin
				fader[i] <= 7'h00;
				knob[i] <= 7'h00;
			end
			chsel <= '0;
			ksel <= '0;
		end else begin
			// R13: reload held values from the snapshot
			if (I_RESTORE) begin
				fader <= snap_fader;
				knob <= snap_knob;
				chsel <= snap_chsel;
				ksel <= snap_ksel;
			end
			// R02 R08: held values come from local positions only
			for (int i = 0; i < NUM_CH; i++) begin
				if (fader_mv[i]) begin
					fader[i] <= I_FADER_POS[i*7 +: 7];
				end
				if (knob_mv[i]) begin
					knob[i] <= I_KNOB_POS[i*7 +: 7];
				end
				// R18: each press toggles the latch
				if (chsel_hit[i]) begin
					chsel[i] <= (I_RESTORE ? snap_chsel[i] : chsel[i]) ^ 1'b1;
				end
				if (ksel_hit[i]) begin
					ksel[i] <= (I_RESTORE ? snap_ksel[i] : ksel[i]) ^ 1'b1;
				end
			end
		end
	end

	// R11 R12: single snapshot slot, overwritten by each take
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < NUM_CH; i++) begin
				snap_fader[i] <= 7'h00;
				snap_knob[i] <= 7'h00;
			end
			snap_chsel <= '0;
			snap_ksel <= '0;
		end else if (I_TAKE) begin
			snap_fader <= fader;
			snap_knob <= knob;
			snap_chsel <= chsel;
			snap_ksel <= ksel;
		end
	end

	// R10: tally lamps follow the latches
	assign O_CHSEL_TALLY = chsel;
	assign O_KSEL_TALLY = ksel;

	// ------------------------------------------------------------
	// pending message flags
	// ------------------------------------------------------------
	logic [NUM_CTL-1:0] pending;
	logic [NUM_CTL-1:0] pend_set;
	logic [NUM_CTL-1:0] pend_clr;
	logic [NUM_CTL-1:0] next_pending;
	logic [5:0] pick;
	mcc_state_t state;
	logic pick_go;

	// one flag per control, index {group, channel}
	always_comb begin
		pend_set = {ksel_hit, chsel_hit, knob_mv, fader_mv};
		// R13 R14: restore and refresh queue every control
		if (I_RESTORE || I_REFRESH) begin
			pend_set = '1;
		end
		pend_clr = '0;
		pend_clr[pick] = pick_go;
		// a new change in the clearing cycle stays queued
		next_pending = (pending & ~pend_clr) | pend_set;
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pending <= '0;
		end else begin
			pending <= next_pending;
		end
	end

	// lowest pending control goes first
	always_comb begin
		pick = 6'h00;
		for (int i = NUM_CTL - 1; i >= 0; i--) begin
			if (pending[i]) begin
				pick = 6'(i);
			end
		end
	end

	// R01: no new message starts while the layer is inactive; one already started finishes
	assign pick_go = (state == ST_IDLE) && I_LAYER_ACTIVE && (|pending);

	// ------------------------------------------------------------
	// controller number and value
	// ------------------------------------------------------------
	logic [1:0] cur_grp;
	logic [3:0] cur_ch;
	logic [6:0] cur_cc;
	logic [1:0] swap_grp;
	logic [6:0] pick_cc;
	logic [6:0] cur_val;

	// R15: swap flips the low group bit
	always_comb begin
		swap_grp = pick[5:4] ^ {1'b0, I_SWAP};
		// R03 R04 R05 R06: group bases plus channel
		unique case (swap_grp)
			GRP_FADER: pick_cc = CC_BASE_FADER | {3'h0, pick[3:0]};
			GRP_KNOB: pick_cc = CC_BASE_KNOB | {3'h0, pick[3:0]};
			GRP_CHSEL: pick_cc = CC_BASE_CHSEL | {3'h0, pick[3:0]};
			GRP_KSEL: pick_cc = CC_BASE_KSEL | {3'h0, pick[3:0]};
		endcase
	end

	// R07 R09: full range for positions, on/off for latches
	always_comb begin
		unique case (cur_grp)
			GRP_FADER: cur_val = fader[cur_ch];
			GRP_KNOB: cur_val = knob[cur_ch];
			GRP_CHSEL: cur_val = chsel[cur_ch] ? VAL_ON : VAL_OFF;
			GRP_KSEL: cur_val = ksel[cur_ch] ? VAL_ON : VAL_OFF;
		endcase
	end

	// ------------------------------------------------------------
	// byte sender
	// ------------------------------------------------------------
	// R17: status, number, value, each held until taken
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state <= ST_IDLE;
			O_TX_BYTE <= 8'h00;
			cur_grp <= 2'h0;
			cur_ch <= 4'h0;
			cur_cc <= 7'h00;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (pick_go) begin
						state <= ST_STAT;
						O_TX_BYTE <= CC_STATUS;
						cur_grp <= pick[5:4];
						cur_ch <= pick[3:0];
						cur_cc <= pick_cc;
					end
				end
				ST_STAT: begin
					if (I_TX_READY) begin
						state <= ST_NUM;
						O_TX_BYTE <= {1'b0, cur_cc};
					end
				end
				ST_NUM: begin
					// value sampled late so the newest position goes out
					if (I_TX_READY) begin
						state <= ST_VAL;
						O_TX_BYTE <= {1'b0, cur_val};
					end
				end
				ST_VAL: begin
					if (I_TX_READY) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign O_TX_VALID = state != ST_IDLE;

	// ------------------------------------------------------------
	// momentary value display
	// ------------------------------------------------------------
	logic [TW-1:0] tick_cnt;
	logic tick;
	logic [7:0] disp_tmr [NUM_CH];

	// millisecond enable for the display timers
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == TW'(TICK_CYC - 1);
			tick_cnt <= (tick_cnt == TW'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
		end
	end

	// R16: a move restarts the channel's display timer
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < NUM_CH; i++) begin
				disp_tmr[i] <= 8'h00;
				O_DISP_VALUE[i*7 +: 7] <= 7'h00;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (fader_mv[i] || knob_mv[i]) begin
					disp_tmr[i] <= DISP_MS;
					O_DISP_VALUE[i*7 +: 7] <= knob_mv[i] ? I_KNOB_POS[i*7 +: 7] : I_FADER_POS[i*7 +: 7];
				end else if (tick && disp_tmr[i] != 8'h00) begin
					disp_tmr[i] <= disp_tmr[i] - 8'h01;
				end
			end
		end
	end

	// label returns when the timer runs out
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			O_DISP_SHOW[i] = disp_tmr[i] != 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);

	chk_status_first: assert property (state == ST_STAT |-> O_TX_BYTE == CC_STATUS) // R01
		else $error("status byte wrong");
	chk_byte_order: assert property ((state == ST_STAT && I_TX_READY) ##1 (state == ST_NUM && I_TX_READY) // R17
		|=> state == ST_VAL && O_TX_BYTE[7] == 1'b0)
		else $error("byte order broken");
	chk_layer_idle: assert property (state == ST_IDLE && !I_LAYER_ACTIVE |=> state == ST_IDLE) // R01
		else $error("sent while layer off");
	chk_fader_number: assert property (state == ST_NUM && cur_grp == GRP_FADER && !$past(I_SWAP, 2) // R03
		&& $past(state, 2) == ST_IDLE |-> O_TX_BYTE == {4'h0, cur_ch})
		else $error("fader number wrong");
	chk_chsel_number: assert property ($rose(state == ST_STAT) && pick_go == 1'b0 && cur_grp == GRP_CHSEL // R05
		&& !$past(I_SWAP) |-> cur_cc == {3'h4, cur_ch})
		else $error("select number wrong");
	chk_swap_knob: assert property ($rose(state == ST_STAT) && cur_grp == GRP_KNOB && $past(I_SWAP) // R15
		|-> cur_cc == {3'h0, cur_ch})
		else $error("swap not applied");
	chk_switch_value: assert property ($rose(state == ST_VAL) && cur_grp[1] // R09
		|-> O_TX_BYTE == (cur_grp[0] ? {1'b0, $past(ksel[cur_ch])} * 8'h7F : {1'b0, $past(chsel[cur_ch])} * 8'h7F))
		else $error("switch value wrong");
	chk_press_toggle: assert property (chsel_hit[0] && !I_RESTORE |=> O_CHSEL_TALLY[0] != $past(O_CHSEL_TALLY[0])) // R18
		else $error("press did not toggle");
	chk_take_copy: assert property (I_TAKE |=> snap_knob[3] == $past(knob[3]) && snap_ksel == $past(ksel)) // R11
		else $error("snapshot not taken");
	chk_refresh_all: assert property ((I_REFRESH || I_RESTORE) |=> pending == '1) // R14
		else $error("refresh not queued");
	chk_disp_show: assert property (fader_mv[2] |=> O_DISP_SHOW[2] [*2]) // R16
		else $error("value not shown");

	cov_fader_msg: cover property ($rose(state == ST_VAL) && cur_grp == GRP_FADER);
	cov_switch_msg: cover property ($rose(state == ST_VAL) && cur_grp == GRP_KSEL);
	cov_restore: cover property (I_RESTORE ##1 state == ST_STAT);
	cov_swap_msg: cover property (I_SWAP && pick_go);
endmodule
`default_nettype wire

// ==== bench/mcc_rx_model.sv ====
// byte sink standing in for the controller message receiver
`timescale 1ns/10ps
`default_nettype none
module mcc_rx_model (
	input wire logic i_clk,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire logic [7:0] i_byte,
	output logic o_ready,
	output logic o_msg,
	output logic [7:0] o_stat,
	output logic [7:0] o_num,
	output logic [7:0] o_val
);
	logic [1:0] cnt;
	initial begin
		o_ready = 1'b0;
		o_msg = 1'b0;
		o_stat = 8'h00;
		o_num = 8'h00;
		o_val = 8'h00;
		cnt = 2'h0;
	end
	// listen only, three bytes make one message
	// random stalls when asked, so the sender must hold its byte
	always @(posedge i_clk) begin
		o_msg <= 1'b0;
		o_ready <= i_stall ? 1'($urandom % 2) : 1'b1;
		if (i_valid === 1'b1 && o_ready) begin
			case (cnt)
				2'h0: o_stat <= i_byte;
				2'h1: o_num <= i_byte;
				default: begin
					o_val <= i_byte;
					o_msg <= 1'b1;
				end
			endcase
			cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ==== bench/mcc_encoder_test.sv ====
// self-checking bench for the surface-to-controller encoder
`timescale 1ns/10ps
`default_nettype none
module mcc_encoder_test;
	import mcc_pkg::*;
	logic clk, arst_n, layer, swap, take, restore, refresh, ready, tx_valid, stall, msg;
	logic [NUM_CH*7-1:0] fpos, kpos, dval;
	logic [NUM_CH-1:0] cpress, kpress, ctally, ktally, dshow, cs, ks, scs, sks;
	logic [7:0] tx_byte, r_stat, r_num, r_val;
	logic [6:0] fv [NUM_CH], kv [NUM_CH], sf [NUM_CH], sk [NUM_CH];
	logic [23:0] q [$];
	int n_fail, check_count;
	mcc_encoder #(.TICK_CYC(2)) mcc_encoder_inst (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_LAYER_ACTIVE(layer),
		.I_SWAP(swap), .I_FADER_POS(fpos), .I_KNOB_POS(kpos), .I_CHSEL_PRESS(cpress), .I_KSEL_PRESS(kpress),
		.I_TAKE(take), .I_RESTORE(restore), .I_REFRESH(refresh), .I_TX_READY(ready), .O_TX_VALID(tx_valid),
		.O_TX_BYTE(tx_byte), .O_CHSEL_TALLY(ctally), .O_KSEL_TALLY(ktally), .O_DISP_SHOW(dshow), .O_DISP_VALUE(dval));
	mcc_rx_model mcc_rx_model_inst (.i_clk(clk), .i_stall(stall), .i_valid(tx_valid), .i_byte(tx_byte),
		.o_ready(ready), .o_msg(msg), .o_stat(r_stat), .o_num(r_num), .o_val(r_val));
	// 250 MHz system clock
	always #2 clk = ~clk;
	task automatic fail_msg(input string m);
		n_fail++;
		$display("FAIL %0t %s", $time, m);
	endtask
	task automatic chk_msg(input logic [23:0] got, input logic [23:0] want);
		check_count++;
		if (got !== want) fail_msg($sformatf("message %h, expected %h", got, want));
	endtask
	task automatic chk_lvl(input logic [111:0] got, input logic [111:0] want, input string m);
		check_count++;
		if (got !== want) fail_msg(m);
	endtask
	// controller number, with swap flipping fader/knob and the two selects
	function automatic logic [6:0] num(input logic [1:0] g, input int i);
		logic [6:0] b;
		case (g ^ {1'b0, swap})
			GRP_FADER: b = CC_BASE_FADER;
			GRP_KNOB: b = CC_BASE_KNOB;
			GRP_CHSEL: b = CC_BASE_CHSEL;
			default: b = CC_BASE_KSEL;
		endcase
		return b + 7'(i);
	endfunction
	task automatic note(input logic [1:0] g, input int i, input logic [6:0] v);
		q.push_back({CC_STATUS, 1'b0, num(g, i), 1'b0, v});
	endtask
	task automatic note_all();
		for (int i = 0; i < NUM_CH; i++) note(GRP_FADER, i, fv[i]);
		for (int i = 0; i < NUM_CH; i++) note(GRP_KNOB, i, kv[i]);
		for (int i = 0; i < NUM_CH; i++) note(GRP_CHSEL, i, cs[i] ? VAL_ON : VAL_OFF);
		for (int i = 0; i < NUM_CH; i++) note(GRP_KSEL, i, ks[i] ? VAL_ON : VAL_OFF);
	endtask
	// bounded wait until every noted message came back
	task automatic drain();
		int k;
		k = 0;
		while (q.size() != 0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (q.size() != 0) fail_msg("messages missing");
		repeat (4) @(posedge clk);
	endtask
	task automatic move(input logic [1:0] g, input int i, input logic [6:0] v);
		@(posedge clk);
		if (g == GRP_FADER) begin
			fpos[i*7+:7] <= v;
			fv[i] = v;
		end else begin
			kpos[i*7+:7] <= v;
			kv[i] = v;
		end
		note(g, i, v);
	endtask
	// one-cycle press, then release, which must stay silent
	task automatic press(input logic [1:0] g, input int i);
		@(posedge clk);
		if (g == GRP_CHSEL) begin
			cpress[i] <= 1'b1;
			cs[i] = ~cs[i];
			note(g, i, cs[i] ? VAL_ON : VAL_OFF);
		end else begin
			kpress[i] <= 1'b1;
			ks[i] = ~ks[i];
			note(g, i, ks[i] ? VAL_ON : VAL_OFF);
		end
		@(posedge clk);
		cpress <= '0;
		kpress <= '0;
		drain();
	endtask
	// 0 take, 1 restore, 2 refresh
	task automatic pulse(input int w);
		@(posedge clk);
		if (w == 0) begin
			take <= 1'b1;
			sf = fv;
			sk = kv;
			scs = cs;
			sks = ks;
		end else if (w == 1) begin
			restore <= 1'b1;
			fv = sf;
			kv = sk;
			cs = scs;
			ks = sks;
			note_all();
		end else begin
			refresh <= 1'b1;
			note_all();
		end
		@(posedge clk);
		take <= 1'b0;
		restore <= 1'b0;
		refresh <= 1'b0;
		drain();
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// each message from the receiver is matched with the oldest note
	always @(posedge clk) begin
		if (msg === 1'b1) begin
			if (q.size() == 0) fail_msg("unexpected message");
			else chk_msg({r_stat, r_num, r_val}, q.pop_front());
		end
	end
	// hang guard, far beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		fail_msg("timeout");
		test_done();
	end
	initial begin
		void'($urandom(32'h9BDD));
		{clk, arst_n, swap, take, restore, refresh, cs, ks, fpos, kpos, cpress, kpress} = '0;
		layer = 1'b1;
		stall = 1'b0;
		n_fail = 0;
		check_count = 0;
		for (int i = 0; i < NUM_CH; i++) {fv[i], kv[i]} = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		stall <= 1'b1;
		// every fader and knob at once, sent in index order
		@(posedge clk);
		for (int i = 0; i < NUM_CH; i++) begin
			fv[i] = (i == 0) ? 7'h7F : 7'($urandom % 127 + 1);
			kv[i] = (i == 15) ? 7'h7F : 7'($urandom % 127 + 1);
			fpos[i*7+:7] <= fv[i];
			kpos[i*7+:7] <= kv[i];
		end
		for (int i = 0; i < NUM_CH; i++) note(GRP_FADER, i, fv[i]);
		for (int i = 0; i < NUM_CH; i++) note(GRP_KNOB, i, kv[i]);
		drain();
		// moved fader shows its value for a while
		move(GRP_FADER, 3, 7'h00);
		repeat (3) @(posedge clk);
		chk_lvl(dshow[3], 1'b1, "display not shown");
		chk_lvl(dval[21+:7], 7'h00, "display value");
		drain();
		repeat (420) @(posedge clk);
		chk_lvl(dshow, '0, "display stuck");
		// nothing leaves while the layer is off
		layer <= 1'b0;
		move(GRP_KNOB, 5, 7'h2A);
		repeat (30) @(posedge clk);
		chk_lvl(112'(q.size()), 112'd1, "sent while layer off");
		chk_lvl(tx_valid, 1'b0, "valid while layer off");
		layer <= 1'b1;
		drain();
		press(GRP_CHSEL, 3);
		press(GRP_CHSEL, 3);
		press(GRP_CHSEL, 15);
		press(GRP_KSEL, 0);
		press(GRP_KSEL, 15);
		press(GRP_CHSEL, 0);
		chk_lvl(ctally, cs, "select tally");
		chk_lvl(ktally, ks, "knob select tally");
		swap <= 1'b1;
		move(GRP_FADER, 2, 7'h11);
		move(GRP_KNOB, 9, 7'h66);
		drain();
		press(GRP_CHSEL, 1);
		press(GRP_KSEL, 2);
		swap <= 1'b0;
		move(GRP_FADER, 1, 7'h21);
		drain();
		pulse(0);
		move(GRP_FADER, 1, 7'h55);
		press(GRP_KSEL, 7);
		pulse(0);
		move(GRP_FADER, 1, 7'h0C);
		press(GRP_CHSEL, 7);
		// restore loads and resends the snapshot
		pulse(1);
		chk_lvl(ctally, cs, "tally after restore");
		chk_lvl(ktally, ks, "knob tally after restore");
		pulse(2);
		test_done();
	end
endmodule
`default_nettype wire
